// *** rtl/zmtpg_top.sv ***
// Zone monitor: gates the pulsed test signal to the safety output, drives the indicators
`timescale 1ns/100ps
module zmtpg_top
#(
  parameter int unsigned TICK_CYC   = zmtpg_pkg::TICK_CYC,
  parameter int unsigned PULSE_CYC  = zmtpg_pkg::PULSE_CYC,
  parameter int unsigned FWD_STAGES = zmtpg_pkg::FWD_STAGES
)
(
  // Clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  // Sensing front end
  input  wire zmtpg_pkg::zmtpg_zone_t   zone_i,
  input  wire logic                 fault_i,
  input  wire logic                 cross_i,
  input  wire zmtpg_pkg::zmtpg_supply_t supply_i,
  // Test pulse link
  input  wire logic                 test_pulse_input_i,
  output logic                      safety_o,
  // Status
  output zmtpg_pkg::zmtpg_led_t     led_o,
  output logic                      adjust_o,
  output logic                      blocked_o
);
  import zmtpg_pkg::*;

  localparam int unsigned PRE_W = $clog2(TICK_CYC + 1);
  localparam int unsigned LO_W  = $clog2(PULSE_CYC + 2);

  // Forward delay must stay below 2 ms and the line needs two stages
  if (FWD_STAGES < 2 || TICK_CYC < 2 || PULSE_CYC < 2
      || (FWD_STAGES + 1) * 1_000_000 / CLK_HZ >= 2000)
  begin : g_bad_param
    $error("zmtpg_top: parameter out of range");
  end

  // Flash taps must sit inside the flash counter
  if (SLOW_BIT >= FLASH_W || FAST_BIT >= FLASH_W || FLICK_BIT >= FLASH_W)
  begin : g_bad_flash
    $error("zmtpg_top: flash tap outside counter");
  end

  // Timer state
  logic [PRE_W-1:0]   pre_q, pre_d;
  logic [MS_W-1:0]    zone_ms_q, zone_ms_d;
  logic [FLASH_W-1:0] flash_q, flash_d;
  logic [MS_W-1:0]    hi_ms_q, hi_ms_d;
  logic [LO_W-1:0]    lo_cyc_q, lo_cyc_d;
  logic [MS_W-1:0]    act_ms_q, act_ms_d;
  zmtpg_zone_t        zone_q, zone_d;
  logic               tick;
  logic               zone_chg;
  logic               inactive;
  logic               stuck;

  // Zone latch state
  logic               pwr_q, pwr_d;
  logic               block_q, block_d;
  logic               adjust_q, adjust_d;
  logic [MS_W-1:0]    ydly_q, ydly_d;
  logic               yhold_q, yhold_d;
  logic               off_now;
  logic               off_prev;

  // Output state
  logic [FWD_STAGES-1:0] pipe_q, pipe_d;
  logic               safety_q, safety_d;
  zmtpg_led_t         led_q, led_d;
  logic               err;
  logic               fwd_ok;

  // Timers; everything slow is counted in 1 ms ticks
  always_comb
  begin
    tick      = (pre_q == PRE_W'(TICK_CYC - 1));
    zone_chg  = (zone_i != zone_q);
    pre_d     = tick ? '0 : pre_q + 1'b1;
    zone_d    = zone_i;
    // A zone change restarts the dwell timer
    if (zone_chg)
      zone_ms_d = '0;
    else if (tick && zone_ms_q != MS_MAX)
      zone_ms_d = zone_ms_q + 1'b1;
    else
      zone_ms_d = zone_ms_q;
    flash_d   = tick ? flash_q + 1'b1 : flash_q;
    // High time of the test input; a long high is a stuck input
    if (!test_pulse_input_i)
      hi_ms_d = '0;
    else if (tick && hi_ms_q != MS_MAX)
      hi_ms_d = hi_ms_q + 1'b1;
    else
      hi_ms_d = hi_ms_q;
    // Low time in cycles; longer than a test pulse means no clock at all
    if (test_pulse_input_i)
      lo_cyc_d = '0;
    else if (lo_cyc_q != LO_W'(PULSE_CYC + 1))
      lo_cyc_d = lo_cyc_q + 1'b1;
    else
      lo_cyc_d = lo_cyc_q;
    inactive  = (lo_cyc_q > LO_W'(PULSE_CYC));
    stuck     = (hi_ms_q > STUCK_MS);
    // Time since the test input became active
    if (inactive || stuck)
      act_ms_d = '0;
    else if (tick && act_ms_q != MS_MAX)
      act_ms_d = act_ms_q + 1'b1;
    else
      act_ms_d = act_ms_q;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      pre_q     <= '0;
      zone_q    <= ZMTPG_Z_NONE;
      zone_ms_q <= '0;
      flash_q   <= '0;
      hi_ms_q   <= '0;
      lo_cyc_q  <= '0;
      act_ms_q  <= '0;
    end
    else
    begin
      pre_q     <= pre_d;
      zone_q    <= zone_d;
      zone_ms_q <= zone_ms_d;
      flash_q   <= flash_d;
      hi_ms_q   <= hi_ms_d;
      lo_cyc_q  <= lo_cyc_d;
      act_ms_q  <= act_ms_d;
    end
  end

  // Zone handling: power-on flag, block and adjust latches, yellow delay and hold
  always_comb
  begin
    // Zone code taken fresh every cycle
    off_now  = (zone_i == ZMTPG_Z_NONE) || (zone_i == ZMTPG_Z_OFF);
    off_prev = (zone_q == ZMTPG_Z_NONE) || (zone_q == ZMTPG_Z_OFF);
    pwr_d    = pwr_q;
    block_d  = block_q;
    adjust_d = adjust_q;
    ydly_d   = ydly_q;
    yhold_d  = yhold_q;

    // Only a first entry from none into the enable zone before the first tick counts as power-on entry
    if (zone_chg && !(zone_q == ZMTPG_Z_NONE && zone_i == ZMTPG_Z_EN
                      && zone_ms_q == '0))
      pwr_d = 1'b0;

    // Close-range dwell latches block, then adjustment mode
    if (zone_i == ZMTPG_Z_CLOSE && !zone_chg)
    begin
      if (zone_ms_q > BLOCK_MS)
        block_d = 1'b1;
      if (zone_ms_q > ADJ_MS)
        adjust_d = 1'b1;
    end
    // Long de-actuation unlocks; power cycle unlocks through reset
    if (off_now && !zone_chg && zone_ms_q > RELEASE_MS)
    begin
      block_d  = 1'b0;
      adjust_d = 1'b0;
    end

    // Yellow delay chosen at the moment of entry into the enable zone
    if (zone_chg && zone_i == ZMTPG_Z_EN)
    begin
      // Fresh flag: a late first entry from none is a re-entry, not power-up
      if (pwr_d)
        ydly_d = PWR_YEL_MS;
      else if (off_prev && zone_ms_q >= OFF_DWELL_MS)
        ydly_d = REENT_YEL_MS;
      else
        ydly_d = '0;
    end
    // Remember whether yellow was lit when the close range was entered
    if (zone_chg && zone_i == ZMTPG_Z_CLOSE)
      yhold_d = led_q.yellow;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      pwr_q    <= 1'b1;
      block_q  <= 1'b0;
      adjust_q <= 1'b0;
      ydly_q   <= '0;
      yhold_q  <= 1'b0;
    end
    else
    begin
      pwr_q    <= pwr_d;
      block_q  <= block_d;
      adjust_q <= adjust_d;
      ydly_q   <= ydly_d;
      yhold_q  <= yhold_d;
    end
  end

  // Output gate and indicators read the live zone_i as well as registered zone state
  always_comb
  begin
    err = fault_i || cross_i || stuck;

    // Yellow indicator
    if (err)
      led_d.yellow = flash_q[FLICK_BIT];
    else if (adjust_q)
      led_d.yellow = (zone_i == ZMTPG_Z_CLOSE || zone_i == ZMTPG_Z_NONE)
                     ? flash_q[SLOW_BIT] : 1'b0;
    else
    begin
      case (zone_i)
        ZMTPG_Z_EN:
          led_d.yellow = !zone_chg && !block_q && zone_ms_q >= ydly_q;
        ZMTPG_Z_CLOSE:
          led_d.yellow = zone_chg ? led_q.yellow
                         : (yhold_q && zone_ms_q < CLOSE_YEL_MS);
        default:
          led_d.yellow = 1'b0;
      endcase
    end

    // Green indicator
    if (err)
      led_d.green = 1'b0;
    else if (supply_i.under)
      led_d.green = flash_q[SLOW_BIT];
    else if (supply_i.over)
      led_d.green = flash_q[FAST_BIT];
    else
      led_d.green = 1'b1;

    // Output gate; indicator timing never enters it
    fwd_ok = (zone_i == ZMTPG_Z_EN) && !zone_chg && zone_ms_q >= ENABLE_MS
             && !fault_i && !block_q && !adjust_q
             && !inactive && !stuck && act_ms_q >= AVAIL_MS;
    // Short shift line is the forward delay, a few cycles only
    pipe_d = {pipe_q[FWD_STAGES-2:0], fwd_ok & test_pulse_input_i};

    // A cross-circuit outranks the safe state so the controller sees it
    if (cross_i)
      safety_d = 1'b1;
    else if (zone_i != ZMTPG_Z_EN || adjust_q)
      safety_d = 1'b0;
    else
      safety_d = pipe_q[FWD_STAGES-1];
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      pipe_q   <= '0;
      safety_q <= 1'b0;
      led_q    <= '0;
    end
    else
    begin
      pipe_q   <= pipe_d;
      safety_q <= safety_d;
      led_q    <= led_d;
    end
  end

  assign safety_o  = safety_q;
  assign led_o     = led_q;
  assign adjust_o  = adjust_q;
  assign blocked_o = block_q;

endmodule

// *** rtl/zmtpg_pkg.sv ***
// Constants, zone codes and carrier types of the zone monitor and test pulse gate
package zmtpg_pkg;

  // Clock rate and time bases
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned TICK_US     = 1000;
  localparam int unsigned TICK_CYC    = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned PULSE_US    = 1000;
  localparam int unsigned PULSE_CYC   = CLK_HZ / 1_000_000 * PULSE_US;

  // Millisecond timer width
  localparam int unsigned MS_W        = 16;
  localparam logic [15:0] MS_MAX      = 16'hffff;

  // Indicator and zone timing, in milliseconds
  localparam logic [15:0] PWR_YEL_MS   = 16'h1388;
  localparam logic [15:0] REENT_YEL_MS = 16'h0bb8;
  localparam logic [15:0] OFF_DWELL_MS = 16'h07d0;
  localparam logic [15:0] CLOSE_YEL_MS = 16'h07d0;
  localparam logic [15:0] BLOCK_MS     = 16'h07d0;
  localparam logic [15:0] ADJ_MS       = 16'h1388;
  localparam logic [15:0] RELEASE_MS   = 16'h07d0;

  // Output timing, in milliseconds
  localparam logic [15:0] ENABLE_MS    = 16'h0064;
  localparam logic [15:0] AVAIL_MS     = 16'h0028;
  localparam logic [15:0] STUCK_MS     = 16'h0064;

  // Forward delay stages and flash rates
  localparam int unsigned FWD_STAGES   = 2;
  localparam int unsigned FLASH_W      = 10;
  localparam int unsigned SLOW_BIT     = 9;
  localparam int unsigned FAST_BIT     = 7;
  localparam int unsigned FLICK_BIT    = 5;

  // Actuator position from the sensing front end
  typedef enum logic [1:0] {
    ZMTPG_Z_NONE  = 2'b00,
    ZMTPG_Z_OFF   = 2'b01,
    ZMTPG_Z_EN    = 2'b10,
    ZMTPG_Z_CLOSE = 2'b11
  } zmtpg_zone_t;

  // Supply monitor flags
  typedef struct packed {
    logic under;
    logic over;
  } zmtpg_supply_t;

  // Indicator drive
  typedef struct packed {
    logic yellow;
    logic green;
  } zmtpg_led_t;

endpackage

// *** test/zmtpg_asserts.sv ***
// Checker of the zone monitor safety output and indicator rules
`timescale 1ns/100ps
module zmtpg_asserts
  import zmtpg_pkg::*;
(
  // Clock and reset
  input wire logic                  clock_i,
  input wire logic                  rst_n_i,
  // Sensing and link inputs
  input wire zmtpg_pkg::zmtpg_zone_t zone_i,
  input wire logic                  fault_i,
  input wire logic                  cross_i,
  input wire logic                  test_pulse_input_i,
  // Outputs
  input wire logic                  safety_o,
  input wire zmtpg_pkg::zmtpg_led_t led_o,
  input wire logic                  adjust_o,
  input wire logic                  blocked_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  property p_leave; zone_i != ZMTPG_Z_EN && !cross_i |=> !safety_o; endproperty
  a_leave: assert property (p_leave) else $error("output high outside zone");
  property p_cross; cross_i |=> safety_o; endproperty
  a_cross: assert property (p_cross) else $error("cross not shown");
  property p_adj; adjust_o && !cross_i |=> !safety_o; endproperty
  a_adj: assert property (p_adj) else $error("output on in adjust");
  property p_blk; blocked_o && !cross_i |=> !safety_o; endproperty
  a_blk: assert property (p_blk) else $error("output on while blocked");
  property p_err; cross_i ##1 cross_i |=> !led_o.green; endproperty
  a_err: assert property (p_err) else $error("green on in error");
  property p_yoff; zone_i == ZMTPG_Z_OFF && !cross_i && !fault_i |=> !led_o.yellow; endproperty
  a_yoff: assert property (p_yoff) else $error("yellow on at off distance");
  // Fault and cross flicker is excluded, it may override the adjust display
  property p_adjy;
    adjust_o && zone_i == ZMTPG_Z_EN && !cross_i && !fault_i |=> !led_o.yellow;
  endproperty
  a_adjy: assert property (p_adjy) else $error("yellow on in adjust");
  property p_fwd; $rose(safety_o) && !$past(cross_i) |-> $past(test_pulse_input_i, 3); endproperty
  a_fwd: assert property (p_fwd) else $error("output rose without input");
endmodule

// *** test/zmtpg_ctrl_model.sv ***
// Controller model: makes the pulsed test signal
`timescale 1ns/100ps
module zmtpg_ctrl_model
(
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // Command: hold the line steady high
  input  wire logic hold_i,
  // Test pulse line
  output logic      pulse_o
);
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  always_comb cnt_d = rst_n_i ? cnt_q + 6'h01 : 6'h00;
  always_ff @(posedge clock_i) cnt_q <= cnt_d;
  // Low pulse of 4 cycles every 64, under the 8 cycle width limit
  // Steady high only on command, a deliberate scheme break
  assign pulse_o = hold_i | (cnt_q[5:2] != 4'h0);
endmodule

// *** test/zmtpg_top_tb.sv ***
// Testbench of the zone monitor and test pulse gate
`timescale 1ns/100ps
module zmtpg_top_tb;
  import zmtpg_pkg::*;
  localparam int T = 4;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  zmtpg_zone_t zone_i  = ZMTPG_Z_EN;
  zmtpg_supply_t supply_i = '0;
  logic        fault_i = 1'b0;
  logic        cross_i = 1'b0;
  logic        hold_i  = 1'b0;
  logic        test_pulse_input_i;
  logic        safety_o;
  zmtpg_led_t  led_o;
  logic        adjust_o;
  logic        blocked_o;
  logic [3:0]  hist;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cycles = 0;
  always #12.5 clock_i = ~clock_i;
  zmtpg_top #(.TICK_CYC(T), .PULSE_CYC(8), .FWD_STAGES(2)) i_zmtpg_top (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .zone_i(zone_i), .fault_i(fault_i),
    .cross_i(cross_i), .supply_i(supply_i),
    .test_pulse_input_i(test_pulse_input_i), .safety_o(safety_o), .led_o(led_o),
    .adjust_o(adjust_o), .blocked_o(blocked_o));
  zmtpg_ctrl_model i_zmtpg_ctrl_model (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .hold_i(hold_i), .pulse_o(test_pulse_input_i));
  always @(posedge clock_i)
  begin
    hist <= {hist[2:0], test_pulse_input_i};
    cycles++;
    if (cycles == 95000)
    begin
      miscompares++;
      finish_test();
    end
  end
  task automatic check(input logic [4:0] seen, input logic [4:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t seen %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic ms(input int n);
    repeat (n * T) @(negedge clock_i);
  endtask
  // Output must copy the input three edges late over two pulse periods
  task automatic fwd;
    repeat (128)
    begin
      @(negedge clock_i);
      check(safety_o, hist[2]);
    end
  endtask
  task automatic t_power;
    ms(201);
    fwd();
    check(led_o.green, 1'b1);
    ms(4667);
    check(led_o.yellow, 1'b0);
    ms(200);
    check(led_o.yellow, 1'b1);
  endtask
  // Bad supply flashes green, slow for under and fast for over
  task automatic t_supply;
    logic g;
    supply_i = '{under: 1'b1, over: 1'b0};
    ms(1);
    g = led_o.green;
    ms(512);
    check(led_o.green, !g);
    supply_i = '{under: 1'b0, over: 1'b1};
    ms(1);
    g = led_o.green;
    ms(128);
    check(led_o.green, !g);
    supply_i = '{under: 1'b0, over: 1'b0};
    ms(1);
    check(led_o.green, 1'b1);
  endtask
  task automatic t_reenter;
    zone_i = ZMTPG_Z_OFF;
    ms(1);
    check({safety_o, led_o.yellow}, 2'b00);
    ms(99);
    zone_i = ZMTPG_Z_EN;
    ms(1);
    check(led_o.yellow, 1'b1);
    zone_i = ZMTPG_Z_OFF;
    ms(2100);
    zone_i = ZMTPG_Z_EN;
    ms(2900);
    check(led_o.yellow, 1'b0);
    ms(200);
    check(led_o.yellow, 1'b1);
  endtask
  task automatic t_close;
    logic s;
    zone_i = ZMTPG_Z_CLOSE;
    ms(1900);
    check({led_o.yellow, blocked_o}, 2'b10);
    ms(200);
    check({led_o.yellow, blocked_o, safety_o}, 3'b010);
    ms(3000);
    check(adjust_o, 1'b1);
    s = led_o.yellow;
    ms(512);
    check(led_o.yellow, !s);
    zone_i = ZMTPG_Z_EN;
    ms(300);
    check({led_o.yellow, safety_o}, 2'b00);
    zone_i = ZMTPG_Z_OFF;
    ms(2100);
    check({adjust_o, blocked_o}, 2'b00);
    zone_i = ZMTPG_Z_EN;
    ms(201);
    fwd();
  endtask
  task automatic t_faults;
    logic y;
    fault_i = 1'b1;
    ms(1);
    check(safety_o, 1'b0);
    fault_i = 1'b0;
    cross_i = 1'b1;
    ms(1);
    check({safety_o, led_o.green}, 2'b10);
    y = led_o.yellow;
    ms(32);
    check(led_o.yellow, !y);
    cross_i = 1'b0;
    hold_i = 1'b1;
    ms(150);
    check(led_o.green, 1'b0);
    hold_i = 1'b0;
  endtask
  // A supply interruption clears the close-range block
  task automatic t_cycle;
    zone_i = ZMTPG_Z_CLOSE;
    ms(2100);
    check({blocked_o, safety_o}, 2'b10);
    rst_n_i = 1'b0;
    repeat (3) @(negedge clock_i);
    check({safety_o, led_o, adjust_o, blocked_o}, 5'h00);
    rst_n_i = 1'b1;
    ms(1);
    check({adjust_o, blocked_o}, 2'b00);
    zone_i = ZMTPG_Z_EN;
    ms(201);
    fwd();
  endtask
  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial
  begin
    repeat (3) @(negedge clock_i);
    rst_n_i = 1'b1;
    t_power();
    t_supply();
    t_reenter();
    t_close();
    t_faults();
    t_cycle();
    finish_test();
  end
endmodule
bind zmtpg_top zmtpg_asserts i_zmtpg_asserts (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .zone_i(zone_i), .fault_i(fault_i),
  .cross_i(cross_i), .test_pulse_input_i(test_pulse_input_i), .safety_o(safety_o),
  .led_o(led_o), .adjust_o(adjust_o), .blocked_o(blocked_o));
